/* logic/scsw_clock_ctrl.sv */
// System clock selection, multiplier, dividers and warm-up timer.
`default_nettype none

module scsw_clock_ctrl #(
  parameter int PERIOD_W = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire scsw_pkg::scsw_bus_req_s bus_req,
  output logic [31:0] rd_data_q,
  // Oscillator pulses, one cycle per oscillator period.
  input wire logic hs_osc_tick,
  input wire logic ls_osc_tick,
  // Power mode and wake event.
  input wire scsw_pkg::scsw_mode_e power_mode,
  input wire logic wake_irq,
  // Oscillator and multiplier run controls.
  output logic hs_osc_on_q,
  output logic ls_osc_on_q,
  output logic multiplier_on_q,
  // Derived clock enable pulses.
  output logic fast_clk_q,
  output logic sys_clk_q,
  output logic core_free_clk_q,
  output logic prescaler_clk_q,
  output logic tick_timer_clk_q,
  // Status.
  output logic warm_busy_q,
  output logic sys_is_slow_q
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (PERIOD_W < 3) begin : g_bad
    $error("scsw_clock_ctrl needs PERIOD_W of at least three.");
  end

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT_OLD,
    SW_WAIT_NEW
  } scsw_sw_e;

  localparam int WW = scsw_pkg::WARM_W;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic sel_slow_q;
  logic pll_sel_q;
  logic hs_en_q;
  logic ls_en_q;
  logic mult_en_q;
  logic wsrc_q;
  logic [2:0] wtime_q;
  logic [1:0] gear_q;
  logic [2:0] prck_q;
  logic fpsel_q;

  // Bus decode.
  logic wr_cs;
  logic wr_ms;
  logic wr_oc;
  logic wr_sc;
  logic [31:0] wd;
  assign wd = bus_req.wdata;
  assign wr_cs = bus_req.wr && (bus_req.addr == scsw_pkg::OFF_CLK_SEL);
  assign wr_ms = bus_req.wr && (bus_req.addr == scsw_pkg::OFF_MULT_SEL);
  assign wr_oc = bus_req.wr && (bus_req.addr == scsw_pkg::OFF_OSC_CTRL);
  assign wr_sc = bus_req.wr && (bus_req.addr == scsw_pkg::OFF_SYS_CTRL);

  // Prescaler ratios above 32 are clamped to 32.
  logic [2:0] prck_wr;
  assign prck_wr = (wd[scsw_pkg::SC_PRCK_LSB +: 3] > scsw_pkg::PRCK_MAX) ?
                   scsw_pkg::PRCK_MAX : wd[scsw_pkg::SC_PRCK_LSB +: 3];

  // Software-written fields; reset values give fast raw oscillator on every clock but the tick timer one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_slow_q <= 1'b0;
      pll_sel_q <= 1'b0;
      hs_en_q <= scsw_pkg::RST_HS_EN;
      ls_en_q <= scsw_pkg::RST_LS_EN;
      mult_en_q <= scsw_pkg::RST_MULT_EN;
      wsrc_q <= 1'b0;
      wtime_q <= 3'h0;
      gear_q <= scsw_pkg::RST_GEAR;
      prck_q <= scsw_pkg::RST_PRCK;
      fpsel_q <= 1'b0;
    end else begin
      if (wr_cs) begin
        sel_slow_q <= wd[scsw_pkg::CS_SEL_BIT];
      end
      if (wr_ms) begin
        pll_sel_q <= wd[scsw_pkg::MS_SEL_BIT];
      end
      if (wr_oc) begin
        hs_en_q <= wd[scsw_pkg::OC_HS_EN_BIT];
        ls_en_q <= wd[scsw_pkg::OC_LS_EN_BIT];
        mult_en_q <= wd[scsw_pkg::OC_MULT_EN_BIT];
        wsrc_q <= wd[scsw_pkg::OC_WSRC_BIT];
        wtime_q <= wd[scsw_pkg::OC_WTIME_LSB +: 3];
      end
      if (wr_sc) begin
        gear_q <= wd[scsw_pkg::SC_GEAR_LSB +: 2];
        prck_q <= prck_wr;
        fpsel_q <= wd[scsw_pkg::SC_FPSEL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Power mode qualifiers
  // ----------------------------------------------------------------
  logic deep_mode;
  logic run_mode;
  assign deep_mode = (power_mode == scsw_pkg::MODE_SLEEP) ||
                     (power_mode == scsw_pkg::MODE_STOP);
  assign run_mode = (power_mode == scsw_pkg::MODE_RUN);

  // Oscillator and multiplier run outputs; multiplier is forced off deep asleep.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hs_osc_on_q <= scsw_pkg::RST_HS_EN;
      ls_osc_on_q <= scsw_pkg::RST_LS_EN;
      multiplier_on_q <= scsw_pkg::RST_MULT_EN;
    end else begin
      hs_osc_on_q <= hs_en_q;
      ls_osc_on_q <= ls_en_q;
      multiplier_on_q <= mult_en_q && !deep_mode;
    end
  end

  // ----------------------------------------------------------------
  // Multiplier: four evenly spaced pulses per fast oscillator period
  // ----------------------------------------------------------------
  logic [PERIOD_W-1:0] per_cnt_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W-1:0] gap_q;
  logic [1:0] sub_left_q;
  logic [PERIOD_W-1:0] quarter;
  logic gap_end;
  logic pll_tick;
  assign quarter = (period_q >> 2) == '0 ? PERIOD_W'(1) : (period_q >> 2);
  assign gap_end = (sub_left_q != 2'h0) && (gap_q == PERIOD_W'(1));
  assign pll_tick = multiplier_on_q && (hs_osc_tick || gap_end);

  // Measures the oscillator period and spaces the extra pulses across it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      per_cnt_q <= '0;
      period_q <= '0;
      gap_q <= '0;
      sub_left_q <= 2'h0;
    end else if (hs_osc_tick) begin
      per_cnt_q <= '0;
      period_q <= per_cnt_q + 1'b1;
      gap_q <= quarter;
      sub_left_q <= 2'(scsw_pkg::MULT_FACTOR - 1);
    end else begin
      if (per_cnt_q != '1) begin
        per_cnt_q <= per_cnt_q + 1'b1;
      end
      if (sub_left_q != 2'h0) begin
        gap_q <= gap_end ? quarter : gap_q - 1'b1;
        sub_left_q <= gap_end ? sub_left_q - 1'b1 : sub_left_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fast clock, gear and prescaler
  // ----------------------------------------------------------------
  logic fast_tick;
  logic gear_tick;
  logic periph_tick;
  assign fast_tick = (pll_sel_q && multiplier_on_q) ? pll_tick : hs_osc_tick;
  assign periph_tick = fpsel_q ? fast_tick : gear_tick;

  // Gear: fast clock divided by 1, 2, 4 or 8.
  scsw_tick_div #(.CNT_W(3), .SEL_W(2)) u_gear (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_in(fast_tick),
    .div_log2(gear_q),
    .tick_out_q(gear_tick)
  );

  // Prescaler: peripheral source divided by 1 to 32.
  scsw_tick_div #(.CNT_W(5), .SEL_W(3)) u_presc (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_in(periph_tick),
    .div_log2(prck_q),
    .tick_out_q(prescaler_clk_q)
  );

  // Tick timer clock: fast oscillator divided by 32.
  scsw_tick_div #(.CNT_W(5), .SEL_W(3)) u_tick ( 
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_in(hs_osc_tick),
    .div_log2(3'(scsw_pkg::TICK_TIMER_LOG2)),
    .tick_out_q(tick_timer_clk_q)
  );

  // ----------------------------------------------------------------
  // Glitch-free system clock switch
  // ----------------------------------------------------------------
  scsw_sw_e sw_q;
  scsw_sw_e sw_d;
  logic flag_slow_d;
  logic old_tick;
  logic new_tick;
  logic sys_tick;
  assign old_tick = sys_is_slow_q ? ls_osc_tick : gear_tick;
  assign new_tick = sys_is_slow_q ? gear_tick : ls_osc_tick;
  assign sys_tick = (sw_q == SW_WAIT_NEW) ? 1'b0 : old_tick;

  // Finish the old source period, hold quiet, then start on a new source edge.
  always_comb begin
    sw_d = sw_q;
    flag_slow_d = sys_is_slow_q;
    case (sw_q)
      SW_IDLE: begin
        if (sel_slow_q != sys_is_slow_q) begin
          sw_d = SW_WAIT_OLD;
        end
      end
      SW_WAIT_OLD: begin
        if (old_tick) begin
          sw_d = SW_WAIT_NEW;
        end
      end
      SW_WAIT_NEW: begin
        if (new_tick) begin
          flag_slow_d = ~sys_is_slow_q;
          sw_d = SW_IDLE;
        end
      end
      default: begin
        sw_d = SW_IDLE;
      end
    endcase
  end

  // Switch state and the status flag.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_q <= SW_IDLE;
      sys_is_slow_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
      sys_is_slow_q <= flag_slow_d;
    end
  end

  // ----------------------------------------------------------------
  // Warm-up timer
  // ----------------------------------------------------------------
  logic [WW-1:0] warm_cnt_q;
  logic [WW-1:0] warm_target;
  logic [4:0] warm_exp;
  logic warm_tick;
  logic warm_start;
  logic wake_start;
  logic warm_done;
  logic wake_hold_q;

  // Exponent of the count for each source and code.
  assign warm_exp = !wsrc_q ? 5'(wtime_q) + 5'(scsw_pkg::FAST_EXP_OFS) :
                    (wtime_q < scsw_pkg::SLOW_HI_FIRST) ?
                    5'(wtime_q) + 5'(scsw_pkg::SLOW_LO_EXP_OFS) :
                    5'(wtime_q) + 5'(scsw_pkg::SLOW_HI_EXP_OFS);
  assign warm_target = WW'(32'h0000_0001 << warm_exp);
  assign warm_tick = wsrc_q ? ls_osc_tick : hs_osc_tick;
  assign wake_start = wake_irq && deep_mode;
  assign warm_start = (wr_oc && wd[scsw_pkg::OC_START_BIT]) || wake_start;
  assign warm_done = warm_busy_q && warm_tick && (warm_cnt_q == warm_target - 1'b1);

  // Counts oscillator periods; code zero ends at once.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      warm_cnt_q <= '0;
      warm_busy_q <= 1'b0;
    end else if (warm_start) begin
      warm_cnt_q <= '0;
      warm_busy_q <= (wtime_q != 3'h0);
    end else if (warm_done) begin
      warm_busy_q <= 1'b0;
    end else if (warm_busy_q && warm_tick) begin
      warm_cnt_q <= warm_cnt_q + 1'b1;
    end
  end

  // Holds the core clock after a wake until warm-up has finished.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_hold_q <= 1'b0;
    end else if (wake_start) begin
      wake_hold_q <= 1'b1;
    end else if (!warm_busy_q) begin
      wake_hold_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Clock enable outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_clk_q <= 1'b0;
      sys_clk_q <= 1'b0;
      core_free_clk_q <= 1'b0;
    end else begin
      fast_clk_q <= fast_tick;
      sys_clk_q <= sys_tick;
      core_free_clk_q <= sys_tick && run_mode && !wake_hold_q;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (bus_req.addr)
      scsw_pkg::OFF_CLK_SEL: begin
        rd_mux[scsw_pkg::CS_SEL_BIT] = sel_slow_q;
        rd_mux[scsw_pkg::CS_FLAG_BIT] = sys_is_slow_q;
      end
      scsw_pkg::OFF_MULT_SEL: begin
        rd_mux[scsw_pkg::MS_SEL_BIT] = pll_sel_q;
      end
      scsw_pkg::OFF_OSC_CTRL: begin
        rd_mux[scsw_pkg::OC_BUSY_BIT] = warm_busy_q;
        rd_mux[scsw_pkg::OC_MULT_EN_BIT] = mult_en_q;
        rd_mux[scsw_pkg::OC_WSRC_BIT] = wsrc_q;
        rd_mux[scsw_pkg::OC_WTIME_LSB +: 3] = wtime_q;
        rd_mux[scsw_pkg::OC_HS_EN_BIT] = hs_en_q;
        rd_mux[scsw_pkg::OC_LS_EN_BIT] = ls_en_q;
      end
      scsw_pkg::OFF_SYS_CTRL: begin
        rd_mux[scsw_pkg::SC_GEAR_LSB +: 2] = gear_q;
        rd_mux[scsw_pkg::SC_PRCK_LSB +: 3] = prck_q;
        rd_mux[scsw_pkg::SC_FPSEL_BIT] = fpsel_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= bus_req.rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

/* logic/scsw_pkg.sv */
// Shared constants and types of the system clock select and warm-up block.
`default_nettype none

package scsw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CLK_SEL = 4'h0;
  localparam logic [3:0] OFF_MULT_SEL = 4'h4;
  localparam logic [3:0] OFF_OSC_CTRL = 4'h8;
  localparam logic [3:0] OFF_SYS_CTRL = 4'hc;

  // system_clock_select fields.
  localparam int CS_FLAG_BIT = 0;
  localparam int CS_SEL_BIT = 1;
  // multiplier_select_reg fields.
  localparam int MS_SEL_BIT = 0;
  // oscillator_control fields.
  localparam int OC_START_BIT = 0;
  localparam int OC_BUSY_BIT = 1;
  localparam int OC_MULT_EN_BIT = 2;
  localparam int OC_WSRC_BIT = 3;
  localparam int OC_WTIME_LSB = 4;
  localparam int OC_HS_EN_BIT = 8;
  localparam int OC_LS_EN_BIT = 9;
  // system_clock_control fields.
  localparam int SC_GEAR_LSB = 0;
  localparam int SC_PRCK_LSB = 4;
  localparam int SC_FPSEL_BIT = 8;

  // Reset values of the stored fields and the prescaler code limit.
  localparam logic RST_HS_EN = 1'h1;
  localparam logic RST_LS_EN = 1'h1;
  localparam logic RST_MULT_EN = 1'h0;
  localparam logic [1:0] RST_GEAR = 2'h0;
  localparam logic [2:0] RST_PRCK = 3'h0;
  localparam logic [2:0] PRCK_MAX = 3'h5;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int WARM_W = 19;
  localparam int FAST_EXP_OFS = 9;
  localparam int SLOW_LO_EXP_OFS = 5;
  localparam int SLOW_HI_EXP_OFS = 11;
  localparam logic [2:0] SLOW_HI_FIRST = 3'h4;
  localparam int MULT_FACTOR = 4;
  localparam int TICK_TIMER_LOG2 = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_SLEEP,
    MODE_STOP
  } scsw_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scsw_bus_req_s;

endpackage

`default_nettype wire

/* logic/scsw_tick_div.sv */
// Power-of-two divider of a one-cycle enable pulse stream.
`default_nettype none

module scsw_tick_div #(
  parameter int CNT_W = 5,
  parameter int SEL_W = 3
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Pulse in, ratio and pulse out.
  input wire logic tick_in,
  input wire logic [SEL_W-1:0] div_log2,
  output logic tick_out_q
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CNT_W < 1 || SEL_W < 1) begin : g_bad
    $error("scsw_tick_div needs CNT_W and SEL_W of at least one.");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;
  logic hit;

  // One pulse out for every 2**div_log2 pulses in.
  assign mask = CNT_W'((32'h0000_0001 << div_log2) - 32'h0000_0001);
  assign hit = tick_in && ((cnt_q & mask) == mask);

  // Counts input pulses and emits the divided pulse.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick_out_q <= 1'b0;
    end else begin
      if (tick_in) begin
        cnt_q <= cnt_q + 1'b1;
      end
      tick_out_q <= hit;
    end
  end

endmodule

`default_nettype wire

/* dv/scsw_clock_ctrl_checker.sv */
// Assertion checker of the clock select and warm-up block.
`default_nettype none

module scsw_clock_ctrl_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire scsw_pkg::scsw_bus_req_s bus_req,
  input wire logic [31:0] rd_data_q,
  // Oscillators, mode and wake.
  input wire logic ls_osc_tick,
  input wire scsw_pkg::scsw_mode_e power_mode,
  input wire logic wake_irq,
  // Watched outputs.
  input wire logic multiplier_on_q,
  input wire logic fast_clk_q,
  input wire logic core_free_clk_q,
  input wire logic warm_busy_q,
  input wire logic sys_is_slow_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Decodes of the register writes and of the power mode.
  wire wr0 = bus_req.wr && bus_req.addr == scsw_pkg::OFF_CLK_SEL;
  wire wr8 = bus_req.wr && bus_req.addr == scsw_pkg::OFF_OSC_CTRL;
  wire run_m = power_mode == scsw_pkg::MODE_RUN;
  wire slp = power_mode == scsw_pkg::MODE_SLEEP || power_mode == scsw_pkg::MODE_STOP;

  // Shadows of the stored source select and warm-up code.
  logic sel_q;
  logic [2:0] code_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_q <= 1'b0;
      code_q <= 3'h0;
    end else begin
      sel_q <= wr0 ? bus_req.wdata[1] : sel_q;
      code_q <= wr8 ? bus_req.wdata[6:4] : code_q;
    end
  end

  property p_core_gate;
    (!run_m) [*2] |-> !core_free_clk_q;
  endproperty
  a_core_gate: assert property (p_core_gate) else $error("core pulse out of run");
  property p_mult_sleep;
    slp [*2] |-> !multiplier_on_q;
  endproperty
  a_mult_sleep: assert property (p_mult_sleep) else $error("multiplier on in sleep");
  property p_mult_on;
    wr8 && bus_req.wdata[2] && run_m |-> ##[1:2] multiplier_on_q;
  endproperty
  a_mult_on: assert property (p_mult_on) else $error("multiplier did not start");
  property p_busy_cause;
    $rose(warm_busy_q) |-> $past(wr8 && bus_req.wdata[0]) || $past(wake_irq);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_code0;
    wr8 && bus_req.wdata[0] && code_q == 3'h0 && !wake_irq |=> !warm_busy_q;
  endproperty
  a_code0: assert property (p_code0) else $error("busy with code zero");
  property p_wake;
    wake_irq && slp && code_q != 3'h0 |=> warm_busy_q;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not start warm-up");
  // A gear pulse always comes with a fast clock pulse, so that one stands for it.
  property p_flag_src;
    $changed(sys_is_slow_q) |-> (sys_is_slow_q ? $past(ls_osc_tick) : $past(fast_clk_q));
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("flag moved off new tick");
  property p_flag_sel;
    $changed(sys_is_slow_q) |-> sys_is_slow_q == sel_q;
  endproperty
  a_flag_sel: assert property (p_flag_sel) else $error("flag differs from select");
  property p_rd_flag;
    bus_req.rd && bus_req.addr == scsw_pkg::OFF_CLK_SEL
      |=> rd_data_q == {30'h0, $past(sel_q), $past(sys_is_slow_q)};
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("select read wrong");
endmodule

bind scsw_clock_ctrl scsw_clock_ctrl_checker u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .bus_req(bus_req),
  .rd_data_q(rd_data_q),
  .ls_osc_tick(ls_osc_tick),
  .power_mode(power_mode),
  .wake_irq(wake_irq),
  .multiplier_on_q(multiplier_on_q),
  .fast_clk_q(fast_clk_q),
  .core_free_clk_q(core_free_clk_q),
  .warm_busy_q(warm_busy_q),
  .sys_is_slow_q(sys_is_slow_q)
);

`default_nettype wire

/* dv/scsw_clock_ctrl_tb.sv */
// Self-checking bench of the clock select and warm-up block.
`default_nettype none

module scsw_clock_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys;
  logic rst;
  scsw_pkg::scsw_bus_req_s bus_req;
  logic [31:0] rd_data_q;
  logic hs_osc_tick;
  logic ls_osc_tick;
  scsw_pkg::scsw_mode_e power_mode;
  logic wake_irq;
  logic hs_on;
  logic ls_on;
  logic mult_on;
  logic fast_clk;
  logic sys_clk;
  logic core_clk;
  logic pre_clk;
  logic tick_clk;
  logic warm_busy_q;
  logic sys_is_slow_q;
  logic rd_prev;
  logic wsrc;
  logic [31:0] exp_q[$];
  int cnt[7];
  int snap[7];
  int d[7];
  int hs_ph = 0;
  int ls_ph = 0;
  int failures = 0;
  int n_compared = 0;

  scsw_clock_ctrl dut (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_data_q(rd_data_q),
    .hs_osc_tick(hs_osc_tick), .ls_osc_tick(ls_osc_tick), .power_mode(power_mode),
    .wake_irq(wake_irq), .hs_osc_on_q(hs_on), .ls_osc_on_q(ls_on),
    .multiplier_on_q(mult_on), .fast_clk_q(fast_clk), .sys_clk_q(sys_clk),
    .core_free_clk_q(core_clk), .prescaler_clk_q(pre_clk), .tick_timer_clk_q(tick_clk),
    .warm_busy_q(warm_busy_q), .sys_is_slow_q(sys_is_slow_q)
  );

  // Clock of 8 ns.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Oscillator pulses: fast every 8 cycles, slow every 12 cycles.
  always @(posedge clk_sys) begin
    hs_ph <= (hs_ph + 1) % 8;
    ls_ph <= (ls_ph + 1) % 12;
    hs_osc_tick <= hs_ph == 3;
    ls_osc_tick <= ls_ph == 7;
  end

  // Read data checked against the oldest note; pulse counters run beside.
  always @(posedge clk_sys) begin
    if (rd_prev && exp_q.size() > 0) chk("rd_data_q", exp_q.pop_front(), rd_data_q);
    rd_prev <= bus_req.rd;
    cnt[0] <= cnt[0] + int'(hs_osc_tick);
    cnt[1] <= cnt[1] + int'(fast_clk);
    cnt[2] <= cnt[2] + int'(sys_clk);
    cnt[3] <= cnt[3] + int'(core_clk);
    cnt[4] <= cnt[4] + int'(pre_clk);
    cnt[5] <= cnt[5] + int'(warm_busy_q && (wsrc ? ls_osc_tick : hs_osc_tick));
    cnt[6] <= cnt[6] + int'(tick_clk);
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compares a pulse count within a tolerance.
  task automatic near(string nm, int e, int g, int t);
    chk(nm, e, (g >= e - t && g <= e + t) ? e : g);
  endtask

  task automatic bw(logic [3:0] a, logic [31:0] dt);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.wdata <= dt;
    bus_req.wr <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic br(logic [3:0] a, logic [31:0] e);
    @(posedge clk_sys);
    exp_q.push_back(e);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
  endtask

  task automatic meas(int n);
    snap = cnt;
    repeat (n) @(posedge clk_sys);
    foreach (d[i]) d[i] = cnt[i] - snap[i];
  endtask

  // Bounded wait; running out counts as a mismatch and ends the run.
  task automatic wt(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) @(posedge clk_sys);
    if (s !== v) begin
      chk("wait", v, s);
      report_and_stop();
    end
  endtask

  // Stores source and code, starts warm-up and counts source pulses.
  task automatic warm(logic src, logic [2:0] code);
    logic [31:0] v;
    int n;
    v = 32'h0000_0300 | (32'(code) << 4) | (32'(src) << 3);
    n = src ? (code < 3'h4 ? code + 5 : code + 11) : code + 9;
    wsrc = src;
    bw(scsw_pkg::OFF_OSC_CTRL, v);
    snap = cnt;
    bw(scsw_pkg::OFF_OSC_CTRL, v | 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk("warm_busy_q", code != 3'h0, warm_busy_q);
    wt(warm_busy_q, 1'b0, 40000);
    if (code != 3'h0) near("warm ticks", 1 << n, cnt[5] - snap[5], 2);
    br(scsw_pkg::OFF_OSC_CTRL, v);
  endtask

  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    rst = 1'b1;
    bus_req = '0;
    power_mode = scsw_pkg::MODE_RUN;
    wake_irq = 1'b0;
    hs_osc_tick = 1'b0;
    ls_osc_tick = 1'b0;
    rd_prev = 1'b0;
    wsrc = 1'b0;
    foreach (cnt[i]) cnt[i] = 0;
    r = $urandom(32'hfb4c_c50a);
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    chk("hs_osc_on_q", 1'b1, hs_on);
    chk("ls_osc_on_q", 1'b1, ls_on);
    chk("multiplier_on_q", 1'b0, mult_on);
    br(scsw_pkg::OFF_CLK_SEL, 32'h0000_0000);
    br(scsw_pkg::OFF_MULT_SEL, 32'h0000_0000);
    br(scsw_pkg::OFF_OSC_CTRL, 32'h0000_0300);
    br(scsw_pkg::OFF_SYS_CTRL, 32'h0000_0000);
    br(4'h2, 32'h0000_0000);
    meas(256);
    near("fast_clk_q", d[0], d[1], 1);
    near("sys_clk_q", d[0], d[2], 1);
    near("prescaler_clk_q", d[0], d[4], 1);
    // Gear ratios with random reserved bits written.
    for (int g = 0; g < 4; g++) begin
      r = $urandom();
      bw(scsw_pkg::OFF_SYS_CTRL, (r & 32'hffff_fe8c) | 32'(g));
      br(scsw_pkg::OFF_SYS_CTRL, 32'(g));
      meas(512);
      near("sys_clk_q", 64 >> g, d[2], 1);
      near("prescaler_clk_q", 64 >> g, d[4], 1);
    end
    // Prescaler ratios from the fast clock; code 6 is held at 5.
    for (int p = 0; p < 7; p++) begin
      bw(scsw_pkg::OFF_SYS_CTRL, 32'h0000_0100 | 32'(p << 4));
      br(scsw_pkg::OFF_SYS_CTRL, 32'h0000_0100 | 32'((p > 5 ? 5 : p) << 4));
      meas(512);
      near("prescaler_clk_q", 64 >> (p > 5 ? 5 : p), d[4], 1);
    end
    bw(scsw_pkg::OFF_SYS_CTRL, 32'h0000_0000);
    // Multiplied fast clock, selected only once a warm-up has covered its settling.
    bw(scsw_pkg::OFF_OSC_CTRL, 32'h0000_0314);
    bw(scsw_pkg::OFF_OSC_CTRL, 32'h0000_0315);
    repeat (3) @(posedge clk_sys);
    chk("multiplier_on_q", 1'b1, mult_on);
    wt(warm_busy_q, 1'b0, 20000);
    bw(scsw_pkg::OFF_MULT_SEL, 32'h0000_0001);
    repeat (40) @(posedge clk_sys);
    meas(256);
    near("fast_clk_q", 128, d[1], 4);
    bw(scsw_pkg::OFF_MULT_SEL, 32'h0000_0000);
    // Low power modes and wake-up warm-up.
    bw(scsw_pkg::OFF_OSC_CTRL, 32'h0000_0314);
    @(posedge clk_sys);
    wake_irq <= 1'b1;
    @(posedge clk_sys);
    wake_irq <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("warm_busy_q", 1'b0, warm_busy_q);
    for (int m = 1; m < 4; m++) begin
      power_mode <= scsw_pkg::scsw_mode_e'(m);
      // Lets the last core pulse of the run mode drain before counting.
      repeat (2) @(posedge clk_sys);
      meas(64);
      near("core_free_clk_q", 0, d[3], 0);
      if (m > 1) chk("multiplier_on_q", 1'b0, mult_on);
    end
    wake_irq <= 1'b1;
    @(posedge clk_sys);
    wake_irq <= 1'b0;
    power_mode <= scsw_pkg::MODE_RUN;
    repeat (2) @(posedge clk_sys);
    chk("warm_busy_q", 1'b1, warm_busy_q);
    meas(256);
    near("core_free_clk_q", 0, d[3], 0);
    wt(warm_busy_q, 1'b0, 20000);
    meas(256);
    near("core_free_clk_q", 32, d[3], 1);
    // Warm-up codes on both sources.
    warm(1'b0, 3'h0);
    warm(1'b0, 3'h1);
    warm(1'b1, 3'h1);
    warm(1'b1, 3'h2);
    warm(1'b1, 3'h3);
    // Switch to the slow clock and back.
    bw(scsw_pkg::OFF_CLK_SEL, 32'h0000_0002);
    wt(sys_is_slow_q, 1'b1, 400);
    br(scsw_pkg::OFF_CLK_SEL, 32'h0000_0003);
    meas(240);
    near("sys_clk_q", 20, d[2], 1);
    near("core_free_clk_q", 20, d[3], 1);
    bw(scsw_pkg::OFF_CLK_SEL, 32'h0000_0000);
    wt(sys_is_slow_q, 1'b0, 400);
    br(scsw_pkg::OFF_CLK_SEL, 32'h0000_0000);
    // Oscillator run outputs follow their enable bits; tick timer is fast / 32.
    bw(scsw_pkg::OFF_OSC_CTRL, 32'h0000_0200);
    repeat (2) @(posedge clk_sys);
    chk("hs_osc_on_q", 1'b0, hs_on);
    chk("ls_osc_on_q", 1'b1, ls_on);
    near("tick_timer_clk_q", cnt[0] / 32, cnt[6], 1);
    repeat (4) @(posedge clk_sys);
    report_and_stop();
  end
endmodule

`default_nettype wire
